// File: pkg/hdlc_pkg.sv
// Contract
// - Three HDLC controllers, each with four receive modes from its own mode field.
// - Channels 2 and 3 behave as channel 1, with their own registers and FIFOs.
// - Lowest mode select bit picks one-byte or two-byte address recognition.
// - Two-byte high address byte compared with FEH, FCH and two programmable values.
// - Command/response bit 1 of the high byte is masked from every compare.
// - Two-byte address valid when high and low bytes both match: eight combinations.
// - Frames matching no address combination are dropped, nothing enters the receive FIFO.
// - One-byte address compared only with the two low-byte compare values.
// - Accepted frames store control, information and status byte; status also readable.
// - Transmitter inserts zero after five ones; receiver deletes those zeros.
// - Mode upper bits 01: addressed frames with flags, CRC and stuffing forwarded.
// - Mode 101: only high byte compared; frame stored without first address byte.
// - Mode 100: no address check, every frame stored, flags CRC stuffing kept.
// - CRC disable: no CRC generated, software supplies it, closing flag only.
// - Transmitter sends any frame length supplied, no length check.
// - Between frames transmitter sends continuous flags when configured.
// - Bit stream uses a selected line time slot, all bits, every frame.
// - Mode 111: raw FIFO data both ways, no flags, CRC or stuffing.
`default_nettype none

package hdlc_pkg;

  // ----------------------------------------------------------------
  // sizes and constants
  // ----------------------------------------------------------------
  localparam int NCH = 3;
  localparam int FIFO_DEPTH = 32;
  localparam logic [5:0] FIFO_FULL = 6'h20;
  localparam logic [7:0] FLAG = 8'h7e;
  localparam logic [7:0] IDLE_ONES = 8'hff;
  localparam logic [7:0] SYNC_BYTE = 8'hff;
  localparam logic [7:0] GROUP_ADDR_A = 8'hfe;
  localparam logic [7:0] GROUP_ADDR_B = 8'hfc;
  localparam logic [7:0] CR_MASK = 8'hfd;
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [15:0] CRC_GOOD = 16'hf0b8;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [2:0] FLAG_RUN = 3'h6;
  localparam logic [2:0] FLAG_TAIL_BITS = 3'h6;

  // ----------------------------------------------------------------
  // mode select encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_NONAUTO = 2'h1;
  localparam logic [2:0] MODE_TRANSP1 = 3'h5;
  localparam logic [2:0] MODE_TRANSP0 = 3'h4;
  localparam logic [2:0] MODE_EXT = 3'h7;

  // ----------------------------------------------------------------
  // status byte field positions
  // ----------------------------------------------------------------
  localparam int ST_VALID = 7;
  localparam int ST_OVERFLOW = 6;
  localparam int ST_CRC_OK = 5;
  localparam int ST_ABORT = 4;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] opModeSelect;
    logic transmitCrcDisable;
    logic flagFill;
    logic [4:0] slot;
    logic [7:0] highAddrCompareA;
    logic [7:0] highAddrCompareB;
    logic [7:0] lowAddrCompareA;
    logic [7:0] lowAddrCompareB;
  } chan_cfg_t;

  typedef struct packed {
    logic transmitTransparentFrameCmd;
    logic transmitterResetCmd;
    logic receiverResetCmd;
  } chan_cmd_t;

  typedef struct packed {
    logic [4:0] slotNum;
    logic bitTick;
    logic rxBit;
  } line_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic last;
  } rx_word_t;

  typedef enum logic [2:0] {TX_IDLE, TX_OPEN, TX_DATA, TX_CRC, TX_CLOSE, TX_RAW} tx_state_t;

  typedef struct packed {
    tx_state_t state;
    logic [7:0] sr;
    logic [2:0] idx;
    logic stuff;
    logic [2:0] ones;
    logic [15:0] crc;
    logic crcHi;
    logic go;
    logic bitOut;
    logic busy;
    logic rdy;
    logic [5:0] rdPtr;
    logic [5:0] wrPtr;
  } tx_t;

  typedef struct packed {
    logic [2:0] ones;
    logic [7:0] sr;
    logic [2:0] cnt;
    logic [15:0] crc;
    logic [2:0] nb;
    logic [7:0] d0;
    logic [7:0] d1;
    logic hiOk;
    logic loOk;
    logic inFrame;
    logic ovf;
    logic [7:0] stat;
  } rx_t;

  typedef struct packed {
    rx_word_t w0;
    rx_word_t w1;
    logic [1:0] n;
    logic v;
  } rxbuf_t;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam tx_t TX_RESET = '{state: TX_IDLE, sr: IDLE_ONES, idx: 3'h0, stuff: 1'b0,
                               ones: 3'h0, crc: CRC_INIT, crcHi: 1'b0, go: 1'b0,
                               bitOut: 1'b1, busy: 1'b0, rdy: 1'b1, rdPtr: 6'h00, wrPtr: 6'h00};
  localparam rx_t RX_RESET = '{ones: 3'h0, sr: 8'h00, cnt: 3'h0, crc: CRC_INIT, nb: 3'h0,
                               d0: 8'h00, d1: 8'h00, hiOk: 1'b0, loOk: 1'b0, inFrame: 1'b0,
                               ovf: 1'b0, stat: 8'h00};
  localparam rxbuf_t RXBUF_RESET = '0;

endpackage

`default_nettype wire

// File: hw/hdlc_signaling_controller.sv
`timescale 1ns/1ps
`default_nettype none

module hdlc_channel (
  input wire logic mclk,
  input wire logic rst_n,
  input wire hdlc_pkg::chan_cfg_t cfg,
  input wire hdlc_pkg::chan_cmd_t cmd,
  input wire hdlc_pkg::line_in_t line,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output var logic txReady,
  output var logic txBit,
  output var logic txBusy,
  output var hdlc_pkg::rx_word_t rxWord,
  output var logic rxValid,
  input wire logic rxReady,
  output var logic [7:0] receiveFrameStatus
);
  import hdlc_pkg::*;

  tx_t txReg;
  tx_t txNext;
  rx_t rxReg;
  rx_t rxNext;
  rxbuf_t bufReg;
  rxbuf_t bufNext;
  logic [7:0] txMem [FIFO_DEPTH];
  logic active;
  logic extMode;
  logic crcOkReg;
  logic crcOkNext;

  // ----------------------------------------------------------------
  // decoding helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] crcStep(input logic [15:0] c, input logic b);
    crcStep = (c >> 1) ^ ((c[0] ^ b) ? CRC_POLY : 16'h0000);
  endfunction

  function automatic logic hiMatch(input logic [7:0] a, input chan_cfg_t c);
    logic [7:0] m;
    m = a & CR_MASK;
    hiMatch = (m == (GROUP_ADDR_A & CR_MASK)) || (m == (GROUP_ADDR_B & CR_MASK)) ||
              (m == (c.highAddrCompareA & CR_MASK)) || (m == (c.highAddrCompareB & CR_MASK));
  endfunction

  function automatic logic loMatch(input logic [7:0] a, input chan_cfg_t c);
    loMatch = (a == c.lowAddrCompareA) || (a == c.lowAddrCompareB);
  endfunction

  function automatic logic accept(input logic [2:0] mode, input logic hi, input logic lo);
    accept = 1'b0;
    if (mode == MODE_TRANSP0) begin
      accept = 1'b1;
    end else if (mode == MODE_TRANSP1) begin
      accept = hi;
    end else if (mode[2:1] == MODE_NONAUTO) begin
      accept = mode[0] ? (hi && lo) : lo;
    end
  endfunction

  function automatic logic [2:0] skipCount(input logic [2:0] mode);
    skipCount = 3'h0;
    if (mode == MODE_TRANSP1) begin
      skipCount = 3'h1;
    end else if (mode[2:1] == MODE_NONAUTO) begin
      skipCount = mode[0] ? 3'h2 : 3'h1;
    end
  endfunction

  // ----------------------------------------------------------------
  // line slot and mode
  // ----------------------------------------------------------------
  // selected time slot
  assign active = line.bitTick && (line.slotNum == cfg.slot);
  assign extMode = (cfg.opModeSelect == MODE_EXT);

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  always_comb begin
    logic [7:0] nextByte;
    logic fifoEmpty;
    logic b;
    txNext = txReg;
    nextByte = txMem[txReg.rdPtr[4:0]];
    fifoEmpty = (txReg.wrPtr == txReg.rdPtr);
    b = txReg.sr[txReg.idx];
    if (txValid && txReg.rdy) begin
      txNext.wrPtr = txReg.wrPtr + 6'h01;
    end
    if (cmd.transmitTransparentFrameCmd) begin
      txNext.go = 1'b1;
    end
    if (active) begin
      // zero insertion
      // pending zero of the last stuffed byte still goes out ahead of the closing flag
      if ((txReg.stuff || (txReg.idx == 3'h0 && txReg.state == TX_CLOSE)) && txReg.ones == STUFF_RUN) begin
        txNext.bitOut = 1'b0;
        txNext.ones = 3'h0;
      end else begin
        txNext.bitOut = b;
        if (!b) begin
          txNext.ones = 3'h0;
        end else if (txReg.ones != 3'h7) begin
          txNext.ones = txReg.ones + 3'h1;
        end
        if (txReg.state == TX_DATA) begin
          txNext.crc = crcStep(txReg.crc, b);
        end
        txNext.idx = txReg.idx + 3'h1;
        if (txReg.idx == 3'h7) begin
          txNext.stuff = 1'b0;
          txNext.sr = (cfg.flagFill && !extMode) ? FLAG : IDLE_ONES;
          unique case (txReg.state)
            TX_IDLE: begin
              if (txReg.go && !fifoEmpty) begin
                txNext.go = 1'b0;
                txNext.state = extMode ? TX_RAW : TX_OPEN;
                txNext.sr = extMode ? SYNC_BYTE : FLAG;
              end
            end
            TX_OPEN: begin
              if (!fifoEmpty) begin
                txNext.sr = nextByte;
                txNext.rdPtr = txReg.rdPtr + 6'h01;
                txNext.stuff = 1'b1;
                txNext.crc = CRC_INIT;
                txNext.state = TX_DATA;
              end else begin
                txNext.state = TX_IDLE;
              end
            end
            TX_DATA: begin
              if (!fifoEmpty) begin
                txNext.sr = nextByte;
                txNext.rdPtr = txReg.rdPtr + 6'h01;
                txNext.stuff = 1'b1;
              end else if (cfg.transmitCrcDisable) begin
                txNext.sr = FLAG;
                txNext.state = TX_CLOSE;
              end else begin
                txNext.sr = ~txNext.crc[7:0];
                txNext.stuff = 1'b1;
                txNext.crcHi = 1'b0;
                txNext.state = TX_CRC;
              end
            end
            TX_CRC: begin
              if (!txReg.crcHi) begin
                txNext.sr = ~txReg.crc[15:8];
                txNext.stuff = 1'b1;
                txNext.crcHi = 1'b1;
              end else begin
                txNext.sr = FLAG;
                txNext.state = TX_CLOSE;
              end
            end
            TX_CLOSE: begin
              txNext.state = TX_IDLE;
            end
            TX_RAW: begin
              if (!fifoEmpty) begin
                txNext.sr = nextByte;
                txNext.rdPtr = txReg.rdPtr + 6'h01;
              end else begin
                txNext.state = TX_IDLE;
              end
            end
          endcase
        end
      end
    end
    if (cmd.transmitterResetCmd) begin
      txNext = TX_RESET;
    end
    txNext.rdy = (6'(txNext.wrPtr - txNext.rdPtr) != FIFO_FULL);
    txNext.busy = (txNext.state != TX_IDLE) || txNext.go;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      txReg <= TX_RESET;
    end else begin
      txReg <= txNext;
    end
  end

  // fifo storage, frame content loaded by software before the start command
  always_ff @(posedge mclk) begin
    if (txValid && txReg.rdy && !cmd.transmitterResetCmd) begin
      txMem[txReg.wrPtr[4:0]] <= txData;
    end
  end

  // ----------------------------------------------------------------
  // receiver and two-entry output buffer
  // ----------------------------------------------------------------
  always_comb begin
    logic b;
    logic dataBit;
    logic endEv;
    logic abortEv;
    logic push;
    logic pop;
    logic space;
    logic [7:0] byteIn;
    logic [7:0] statusByte;
    rx_word_t pushWord;
    rxNext = rxReg;
    crcOkNext = crcOkReg;
    bufNext = bufReg;
    b = line.rxBit;
    dataBit = 1'b0;
    endEv = 1'b0;
    abortEv = 1'b0;
    push = 1'b0;
    pushWord = '0;
    byteIn = {b, rxReg.sr[7:1]};
    pop = bufReg.v && rxReady;
    space = (bufReg.n != 2'h2) || pop;
    if (active) begin
      if (extMode) begin
        rxNext.sr = byteIn;
        rxNext.cnt = rxReg.cnt + 3'h1;
        if (rxReg.cnt == 3'h7) begin
          push = 1'b1;
          pushWord = '{data: byteIn, last: 1'b0};
        end
      end else if (b) begin
        if (rxReg.ones == FLAG_RUN) begin
          abortEv = 1'b1;
          rxNext.ones = 3'h7;
        end else if (rxReg.ones != 3'h7) begin
          rxNext.ones = rxReg.ones + 3'h1;
          dataBit = (rxReg.ones < STUFF_RUN);
        end
      end else begin
        rxNext.ones = 3'h0;
        if (rxReg.ones == FLAG_RUN) begin
          endEv = 1'b1;
        end else begin
          dataBit = (rxReg.ones != STUFF_RUN);
        end
      end
    end
    statusByte = '0;
    // crc judged at the last whole byte, before the flag's leading bits
    statusByte[ST_CRC_OK] = crcOkReg;
    statusByte[ST_VALID] = crcOkReg && (rxReg.cnt == FLAG_TAIL_BITS) && !abortEv;
    statusByte[ST_OVERFLOW] = rxReg.ovf;
    statusByte[ST_ABORT] = abortEv;
    if (dataBit && rxReg.inFrame) begin
      rxNext.sr = byteIn;
      rxNext.crc = crcStep(rxReg.crc, b);
      rxNext.cnt = rxReg.cnt + 3'h1;
      if (rxReg.cnt == 3'h7) begin
        crcOkNext = (rxNext.crc == CRC_GOOD);
        if (rxReg.nb == 3'h0) begin
          rxNext.hiOk = hiMatch(byteIn, cfg);
          rxNext.loOk = loMatch(byteIn, cfg);
        end
        if (rxReg.nb == 3'h1 && cfg.opModeSelect[2:1] == MODE_NONAUTO && cfg.opModeSelect[0]) begin
          rxNext.loOk = loMatch(byteIn, cfg);
        end
        if (rxReg.nb >= 3'h2 && accept(cfg.opModeSelect, rxReg.hiOk, rxReg.loOk) &&
            3'(rxReg.nb - 3'h2) >= skipCount(cfg.opModeSelect)) begin
          push = 1'b1;
          pushWord = '{data: rxReg.d1, last: 1'b0};
        end
        rxNext.d1 = rxReg.d0;
        rxNext.d0 = byteIn;
        if (rxReg.nb != 3'h7) begin
          rxNext.nb = rxReg.nb + 3'h1;
        end
      end
    end
    if ((endEv || abortEv) && rxReg.inFrame && rxReg.nb >= 3'h2 &&
        accept(cfg.opModeSelect, rxReg.hiOk, rxReg.loOk)) begin
      push = 1'b1;
      pushWord = '{data: statusByte, last: 1'b1};
      rxNext.stat = statusByte;
    end
    if (pop) begin
      bufNext.w0 = bufReg.w1;
      bufNext.n = bufReg.n - 2'h1;
    end
    if (push) begin
      if (space) begin
        if (bufNext.n == 2'h0) begin
          bufNext.w0 = pushWord;
        end else begin
          bufNext.w1 = pushWord;
        end
        bufNext.n = bufNext.n + 2'h1;
      end else begin
        rxNext.ovf = 1'b1;
      end
    end
    if (endEv) begin
      rxNext.inFrame = 1'b1;
      rxNext.nb = 3'h0;
      rxNext.cnt = 3'h0;
      rxNext.crc = CRC_INIT;
      rxNext.hiOk = 1'b0;
      rxNext.loOk = 1'b0;
      rxNext.ovf = 1'b0;
      crcOkNext = 1'b0;
    end
    if (abortEv) begin
      rxNext.inFrame = 1'b0;
    end
    bufNext.v = (bufNext.n != 2'h0);
    if (cmd.receiverResetCmd) begin
      rxNext = RX_RESET;
      bufNext = RXBUF_RESET;
      crcOkNext = 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rxReg <= RX_RESET;
      crcOkReg <= 1'b0;
      bufReg <= RXBUF_RESET;
    end else begin
      rxReg <= rxNext;
      crcOkReg <= crcOkNext;
      bufReg <= bufNext;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign txReady = txReg.rdy;
  assign txBit = txReg.bitOut;
  assign txBusy = txReg.busy;
  assign rxWord = bufReg.w0;
  assign rxValid = bufReg.v;
  assign receiveFrameStatus = rxReg.stat;

endmodule // hdlc_channel

module hdlc_signaling_controller (
  input wire logic mclk,
  input wire logic rst_n,
  input wire hdlc_pkg::chan_cfg_t [hdlc_pkg::NCH-1:0] cfg,
  input wire hdlc_pkg::chan_cmd_t [hdlc_pkg::NCH-1:0] cmd,
  input wire hdlc_pkg::line_in_t line,
  input wire logic [hdlc_pkg::NCH-1:0][7:0] txData,
  input wire logic [hdlc_pkg::NCH-1:0] txValid,
  output wire logic [hdlc_pkg::NCH-1:0] txReady,
  output wire logic [hdlc_pkg::NCH-1:0] txBit,
  output wire logic [hdlc_pkg::NCH-1:0] txBusy,
  output wire hdlc_pkg::rx_word_t [hdlc_pkg::NCH-1:0] rxWord,
  output wire logic [hdlc_pkg::NCH-1:0] rxValid,
  input wire logic [hdlc_pkg::NCH-1:0] rxReady,
  output wire logic [hdlc_pkg::NCH-1:0][7:0] receiveFrameStatus
);
  import hdlc_pkg::*;

  // ----------------------------------------------------------------
  // channels
  // ----------------------------------------------------------------
  // three controllers
  for (genvar g = 0; g < NCH; g++) begin : gen_chan
    hdlc_channel u_chan (
      .mclk(mclk),
      .rst_n(rst_n),
      .cfg(cfg[g]),
      .cmd(cmd[g]),
      .line(line),
      .txData(txData[g]),
      .txValid(txValid[g]),
      .txReady(txReady[g]),
      .txBit(txBit[g]),
      .txBusy(txBusy[g]),
      .rxWord(rxWord[g]),
      .rxValid(rxValid[g]),
      .rxReady(rxReady[g]),
      .receiveFrameStatus(receiveFrameStatus[g])
    );
  end

endmodule // hdlc_signaling_controller

`default_nettype wire

// File: bench/hdlc_controller_asserts.sv
`timescale 1ns/1ps
`default_nettype none

module hdlc_controller_asserts (
  input wire logic mclk,
  input wire logic rst_n,
  input wire hdlc_pkg::chan_cfg_t [hdlc_pkg::NCH-1:0] cfg,
  input wire hdlc_pkg::chan_cmd_t [hdlc_pkg::NCH-1:0] cmd,
  input wire hdlc_pkg::line_in_t line,
  input wire logic [hdlc_pkg::NCH-1:0][7:0] txData,
  input wire logic [hdlc_pkg::NCH-1:0] txValid,
  input wire logic [hdlc_pkg::NCH-1:0] txReady,
  input wire logic [hdlc_pkg::NCH-1:0] txBit,
  input wire logic [hdlc_pkg::NCH-1:0] txBusy,
  input wire hdlc_pkg::rx_word_t [hdlc_pkg::NCH-1:0] rxWord,
  input wire logic [hdlc_pkg::NCH-1:0] rxValid,
  input wire logic [hdlc_pkg::NCH-1:0] rxReady,
  input wire logic [hdlc_pkg::NCH-1:0][7:0] receiveFrameStatus
);
  import hdlc_pkg::*;
  wire logic act0;
  assign act0 = line.bitTick && (line.slotNum == cfg[0].slot);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_txbit_hold;
    !$past(act0) && !$past(cmd[0].transmitterResetCmd) && !$past(cmd[0].transmitterResetCmd, 2)
      |-> $stable(txBit[0]);
  endproperty
  a_txbit_hold: assert property (p_txbit_hold) else $error("txBit moved off its slot");
  property p_ready_fell;
    $fell(txReady[2]) |-> $past(txValid[2]);
  endproperty
  a_ready_fell: assert property (p_ready_fell) else $error("txReady fell without a write");
  property p_busy_cmd;
    cmd[0].transmitTransparentFrameCmd && !cmd[0].transmitterResetCmd |=> txBusy[0];
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("txBusy missing after command");
  property p_busy_own;
    $rose(txBusy[1]) |-> $past(cmd[1].transmitTransparentFrameCmd);
  endproperty
  a_busy_own: assert property (p_busy_own) else $error("txBusy rose without own command");
  property p_rx_hold;
    rxValid[1] && !rxReady[1] && !cmd[1].receiverResetCmd && !$past(cmd[1].receiverResetCmd)
      |=> rxValid[1] && $stable(rxWord[1]);
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx word lost while stalled");
  property p_stat_bits;
    rxValid[0] && rxWord[0].last
      |-> rxWord[0].data[3:0] == 4'h0 && (!rxWord[0].data[7] || (rxWord[0].data[5] && !rxWord[0].data[4]));
  endproperty
  a_stat_bits: assert property (p_stat_bits) else $error("status byte fields inconsistent");
  property p_stat_copy;
    $changed(receiveFrameStatus[0]) |-> ##[0:2] rxValid[0];
  endproperty
  a_stat_copy: assert property (p_stat_copy) else $error("status changed with nothing stored");
  property p_rx_rose;
    $rose(rxValid[0]) |-> $past(act0) || $past(act0, 2) || $past(act0, 3) || $past(rxReady[0]);
  endproperty
  a_rx_rose: assert property (p_rx_rose) else $error("rxValid rose away from a line bit");
endmodule // hdlc_controller_asserts

bind hdlc_signaling_controller hdlc_controller_asserts u_hdlc_controller_asserts (
  .mclk(mclk), .rst_n(rst_n), .cfg(cfg), .cmd(cmd), .line(line), .txData(txData), .txValid(txValid),
  .txReady(txReady), .txBit(txBit), .txBusy(txBusy), .rxWord(rxWord), .rxValid(rxValid),
  .rxReady(rxReady), .receiveFrameStatus(receiveFrameStatus));

`default_nettype wire

// File: bench/hdlc_remote_station.sv
`timescale 1ns/1ps
`default_nettype none

module hdlc_remote_station (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [hdlc_pkg::NCH-1:0] txBit,
  output var hdlc_pkg::line_in_t line
);
  import hdlc_pkg::*;
  logic [1:0] phaseReg;
  logic [1:0] phaseNext;
  line_in_t lineReg;
  line_in_t lineNext;
  // ----
  // slot rotation over four slots, far end echoes slots 0 to 2 back, slot 3 toggles
  // ----
  // slot carries stream
  always_comb begin
    phaseNext = phaseReg + 2'h1;
    lineNext = lineReg;
    lineNext.bitTick = (phaseReg == 2'h3);
    lineNext.rxBit = ~lineReg.rxBit;
    if (phaseReg == 2'h3) begin
      lineNext.slotNum = (lineReg.slotNum == 5'h3) ? 5'h0 : lineReg.slotNum + 5'h1;
      if (lineNext.slotNum < 5'h3) begin
        lineNext.rxBit = txBit[lineNext.slotNum[1:0]];
      end
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      phaseReg <= 2'h0;
      lineReg <= '0;
    end else begin
      phaseReg <= phaseNext;
      lineReg <= lineNext;
    end
  end
  assign line = lineReg;
endmodule // hdlc_remote_station

`default_nettype wire

// File: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import hdlc_pkg::*;
  logic mclk;
  logic rst_n;
  chan_cfg_t [NCH-1:0] cfg;
  chan_cmd_t [NCH-1:0] cmd;
  line_in_t line;
  logic [NCH-1:0][7:0] txData;
  logic [NCH-1:0] txValid;
  logic [NCH-1:0] txReady;
  logic [NCH-1:0] txBit;
  logic [NCH-1:0] txBusy;
  rx_word_t [NCH-1:0] rxWord;
  logic [NCH-1:0] rxValid;
  logic [NCH-1:0] rxReady;
  logic [NCH-1:0][7:0] receiveFrameStatus;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  int z;
  rx_word_t w;

  hdlc_signaling_controller u_hdlc_signaling_controller (.mclk(mclk), .rst_n(rst_n), .cfg(cfg), .cmd(cmd),
    .line(line), .txData(txData), .txValid(txValid), .txReady(txReady), .txBit(txBit), .txBusy(txBusy),
    .rxWord(rxWord), .rxValid(rxValid), .rxReady(rxReady), .receiveFrameStatus(receiveFrameStatus));
  hdlc_remote_station u_hdlc_remote_station (.mclk(mclk), .rst_n(rst_n), .txBit(txBit), .line(line));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      errors++;
      report_and_stop();
    end
  end

  // ----
  // helpers
  // ----
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [15:0] fcs(logic [7:0] a, logic [7:0] c);
    logic [15:0] r;
    r = CRC_INIT;
    for (int i = 0; i < 16; i++) r = (r[0] ^ (i < 8 ? a[i] : c[i-8])) ? (r >> 1) ^ CRC_POLY : r >> 1;
    return ~r;
  endfunction
  task automatic send(int ch, logic [7:0] b[4]);
    for (int i = 0; i < 4; i++) begin
      txData[ch] <= b[i];
      txValid[ch] <= 1'b1;
      do @(posedge mclk); while (txReady[ch] !== 1'b1);
    end
    txValid[ch] <= 1'b0;
    cmd[ch].transmitTransparentFrameCmd <= 1'b1;
    @(posedge mclk);
    cmd[ch].transmitTransparentFrameCmd <= 1'b0;
  endtask
  task automatic recv(int ch, output rx_word_t rw);
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (rxValid[ch] !== 1'b1 && n < 3000);
    rw = rxWord[ch];
  endtask
  task automatic drain(int ch);
    int n;
    @(posedge mclk);
    for (n = 0; n < 3000 && txBusy[ch] !== 1'b0; n++) @(posedge mclk);
    repeat (64) @(posedge mclk);
  endtask
  task automatic idle(logic fill, output int zc);
    cfg[0].flagFill <= fill;
    repeat (200) @(posedge mclk);
    zc = 0;
    repeat (256) begin
      @(posedge mclk);
      zc += int'(txBit[0] === 1'b0);
    end
  endtask
  // one frame looped back: skip address bytes, expect status or nothing
  task automatic frame(int ch, logic [2:0] mode, logic crcOff, int skip, logic acc, logic [7:0] stat,
                       logic [7:0] b[4]);
    rx_word_t rw;
    int last;
    logic [15:0] f;
    f = fcs(b[0], b[1]);
    if (crcOff && stat[7]) begin
      b[2] = f[7:0];
      b[3] = f[15:8];
    end
    cfg[ch].opModeSelect <= mode;
    cfg[ch].transmitCrcDisable <= crcOff;
    @(posedge mclk);
    send(ch, b);
    last = crcOff ? 2 : 4;
    if (acc) begin
      for (int i = skip; i <= last; i++) begin
        recv(ch, rw);
        check("rxWord.data", (i < last) ? b[i] : stat, rw.data);
        check("rxWord.last", {7'h0, i == last}, {7'h0, rw.last});
      end
      @(posedge mclk);
      check("receiveFrameStatus", stat, receiveFrameStatus[ch]);
    end
    drain(ch);
    check("rxValid", 8'h0, {7'h0, rxValid[ch]});
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    rst_n = 1'b0;
    txValid = '0;
    txData = '0;
    rxReady = '1;
    cmd = '0;
    for (int i = 0; i < NCH; i++) cfg[i] = '{3'h4, 1'b0, 1'b0, 5'(i), 8'h10, 8'h20, 8'h31, 8'h32};
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < NCH; i++) cmd[i] <= 3'h3;
    @(posedge mclk);
    cmd <= '0;
    idle(1'b0, z);
    check("idleZeros", 8'h1, {7'h0, z == 0});
    idle(1'b1, z);
    check("flagZeros", 8'h1, {7'h0, z > 0});
    cfg[0].opModeSelect <= 3'h7;
    idle(1'b1, z);
    check("rawIdleZeros", 8'h1, {7'h0, z == 0});
    frame(0, 3'h4, 1'b0, 0, 1'b1, 8'ha0, '{8'hff, 8'h3e, 8'hf8, 8'h7e});
    frame(1, 3'h3, 1'b0, 2, 1'b1, 8'ha0, '{8'hfe, 8'h31, 8'h03, 8'h55});
    frame(2, 3'h3, 1'b0, 2, 1'b1, 8'ha0, '{8'h12, 8'h32, 8'h13, 8'haa});
    frame(0, 3'h3, 1'b0, 2, 1'b0, 8'h00, '{8'h20, 8'h35, 8'h03, 8'h55});
    frame(1, 3'h3, 1'b0, 2, 1'b0, 8'h00, '{8'h40, 8'h31, 8'h03, 8'h55});
    frame(2, 3'h2, 1'b0, 1, 1'b1, 8'ha0, '{8'h31, 8'h03, 8'h55, 8'h66});
    frame(0, 3'h2, 1'b0, 1, 1'b0, 8'h00, '{8'hfe, 8'h03, 8'h55, 8'h66});
    frame(1, 3'h5, 1'b0, 1, 1'b1, 8'ha0, '{8'h22, 8'h77, 8'h03, 8'h55});
    frame(2, 3'h5, 1'b0, 1, 1'b0, 8'h00, '{8'h31, 8'h32, 8'h03, 8'h55});
    frame(0, 3'h4, 1'b1, 0, 1'b1, 8'ha0, '{8'h01, 8'h02, 8'h00, 8'h00});
    frame(1, 3'h4, 1'b1, 0, 1'b1, 8'h00, '{8'h01, 8'h02, 8'h00, 8'h00});
    cfg[1].transmitCrcDisable <= 1'b0;
    rxReady[1] <= 1'b0;
    @(posedge mclk);
    send(1, '{8'h11, 8'h22, 8'h33, 8'h44});
    drain(1);
    rxReady[1] <= 1'b1;
    recv(1, w);
    check("stallWord0", 8'h11, w.data);
    recv(1, w);
    check("stallWord1", 8'h22, w.data);
    repeat (8) @(posedge mclk);
    check("stallEmpty", 8'h0, {7'h0, rxValid[1]});
    txValid[2] <= 1'b1;
    repeat (32) @(posedge mclk);
    txValid[2] <= 1'b0;
    @(posedge mclk);
    check("txReadyFull", 8'h0, {7'h0, txReady[2]});
    cmd[2].transmitterResetCmd <= 1'b1;
    @(posedge mclk);
    cmd[2].transmitterResetCmd <= 1'b0;
    repeat (3) @(posedge mclk);
    check("txReadyFlushed", 8'h1, {7'h0, txReady[2]});
    report_and_stop();
  end
endmodule // tb

`default_nettype wire
